// >>> common/charger_input_supervisor_consts.vh
`ifndef CHARGER_INPUT_SUPERVISOR_CONSTS_VH
`define CHARGER_INPUT_SUPERVISOR_CONSTS_VH

// ************************************************
// Measurement and current widths
// ************************************************
`define MV_W 14
`define MA_W 12

// ************************************************
// Supply thresholds in millivolts
// ************************************************
`define OVP_MV_SEL0 14'd6600
`define OVP_MV_SEL1 14'd7000
`define OVP_MV_SEL2 14'd7500
`define OVP_MV_SEL3 14'd8000
`define OVP_RESUME_MV 14'd6000
`define UVLO_MV 14'd3500
`define UVLO_HYST_MV 14'd500
`define WALL_THRESH_MV 14'd1200
`define RAIL_SAG_MV 14'd200
`define RAIL_NOMINAL_RESET 14'd4000

// ************************************************
// Current settings in milliamps and current divisors
// ************************************************
`define USB_LOW_LIMIT_MA 12'd100
`define USB_HIGH_LIMIT_MA 12'd450
`define AC_LIMIT_MA 12'd2000
`define USB_LOW_FAST_MA 12'd90
`define USB_HIGH_FAST_MA 12'd450
`define USB_PRE_MA 12'd45
`define AC_LOW_DIVISOR 12'd5
`define AC_PRE_DIVISOR 12'd10

// ************************************************
// Register map (byte addresses)
// ************************************************
`define ADDR_W 12
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_CURRENT 12'h008
`define REG_RAIL_NOMINAL 12'h00C

// ************************************************
// Control fields
// ************************************************
`define CTL_OVP_LSB 0
`define CTL_FLAG_EN_BIT 2
`define CTL_CONNECT_EN_BIT 3
`define CTL_DISCONNECT_EN_BIT 4
`define CTL_W 5
`define CTL_RESET 5'h00

// ************************************************
// Status fields
// ************************************************
`define ST_EVENT_BIT 0
`define ST_VALID_BIT 1
`define ST_WALL_BIT 2
`define ST_OVP_BIT 3
`define ST_UV_BIT 4
`define ST_CHARGE_BIT 5
`define ST_DYNAMIC_CHARGE_CURRENT_CONTROL_BIT 6
`define ST_PATH_SUPPLY_BIT 7
`define ST_PATH_BATTERY_BIT 8

`endif

// >>> core/charger_input_supervisor.v
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"

// What this block does
// - Block charging when supply exceeds the selected 6.6/7.0/7.5/8.0 V limit.
// - After over-voltage, stay blocked until supply drops below 6.0 V.
// - Input limit 100 or 450 mA in USB mode, 2 A in wall mode.
// - Wall mode when the wall select level is above 1.2 V.
// - Under 3.5 V flag under-voltage; resume only 500 mV above it.
// - Fast current chosen from wall and level selects; precondition from wall select only.
// - Cut charge current when the system rail sags over 200 mV.
// - Power path: supply, battery, or both when demand exceeds capability.
// - Connect events interrupt when flag enable and connect enable are set.
// - Disconnect events interrupt when flag enable and disconnect enable set.
// - Valid status is 1 only between under- and over-voltage limits.
// - Event flag reads 1 after an interrupt and clears on read.
// - Wall status readable anytime, 1 above threshold, 0 for USB.
// - Interrupt line low until status has been read, whether or not the cause is gone.
module charger_input_supervisor (
    input wire clock_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [`ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire [`MV_W-1:0] charger_supply_input_mv_in,
    input wire [`MV_W-1:0] wall_input_select_mv_in,
    input wire charge_level_select_in,
    input wire [`MA_W-1:0] charge_current_resistance_ma_in,
    input wire [`MV_W-1:0] system_rail_mv_in,
    input wire [`MA_W-1:0] system_demand_ma_in,
    output reg charge_enable_out,
    output reg [`MA_W-1:0] input_limit_ma_out,
    output reg [`MA_W-1:0] fast_charge_ma_out,
    output reg [`MA_W-1:0] precondition_ma_out,
    output reg dynamic_charge_current_control_out,
    output reg path_supply_on_out,
    output reg path_battery_on_out,
    output reg interrupt_request_n_out
);
    // ************************************************
    // Registers and wires
    // ************************************************
    reg [`CTL_W-1:0] control_q;
    reg [`CTL_W-1:0] control_d;
    reg [`MV_W-1:0] rail_nominal_q;
    reg [`MV_W-1:0] rail_nominal_d;
    reg event_flag_q;
    reg event_flag_d;
    reg valid_prev_q;
    reg wall_mode_q;
    reg rail_sag_q;
    reg rail_sag_d;
    reg [31:0] rdata_d;
    reg err_d;
    reg charge_d;
    reg path_supply_d;
    reg path_battery_d;
    wire over_voltage;
    wire under_voltage;
    wire input_valid;
    wire [`MA_W-1:0] limit_ma;
    wire [`MA_W-1:0] fast_ma;
    wire [`MA_W-1:0] pre_ma;
    wire [1:0] ovp_threshold_select;
    wire flag_enable;
    wire connect_event_enable;
    wire disconnect_event_enable;
    wire connect_event;
    wire disconnect_event;
    wire event_set;
    wire apb_access;
    wire apb_done;
    wire apb_write;
    wire apb_read;
    wire status_read;
    wire addr_mapped;
    wire [31:0] status_word;
    wire [31:0] current_word;

    assign ovp_threshold_select = control_q[`CTL_OVP_LSB+1:`CTL_OVP_LSB];
    assign flag_enable = control_q[`CTL_FLAG_EN_BIT];
    assign connect_event_enable = control_q[`CTL_CONNECT_EN_BIT];
    assign disconnect_event_enable = control_q[`CTL_DISCONNECT_EN_BIT];

    // ************************************************
    // Supply qualification and current selection
    // ************************************************
    supply_qualifier u_qualifier (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .supply_mv_in(charger_supply_input_mv_in),
        .ovp_threshold_select_in(ovp_threshold_select),
        .over_voltage_out(over_voltage),
        .under_voltage_out(under_voltage),
        .input_valid_out(input_valid)
    );

    current_mode_select u_current (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .wall_mode_in(wall_mode_q),
        .charge_level_select_in(charge_level_select_in),
        .rail_sag_in(rail_sag_q),
        .resistor_ma_in(charge_current_resistance_ma_in),
        .input_limit_ma_out(limit_ma),
        .fast_ma_out(fast_ma),
        .pre_ma_out(pre_ma)
    );

    // ************************************************
    // Rail sag detection
    // ************************************************
    always @* begin
        rail_sag_d = 1'b0;
        // Guard against underflow when the nominal is set very low
        if (rail_nominal_q > `RAIL_SAG_MV) begin
            rail_sag_d = system_rail_mv_in < (rail_nominal_q - `RAIL_SAG_MV);
        end
    end

    // ************************************************
    // Input events
    // ************************************************
    assign connect_event = input_valid & ~valid_prev_q;
    assign disconnect_event = ~input_valid & valid_prev_q;
    assign event_set = flag_enable &
        ((connect_event & connect_event_enable) |
         (disconnect_event & disconnect_event_enable));

    // ************************************************
    // APB slave
    // ************************************************
    // Every access takes one wait state so read data come from a flop
    assign apb_access = psel_in & penable_in;
    assign apb_done = apb_access & pready_out;
    assign apb_write = apb_done & pwrite_in;
    assign apb_read = apb_done & ~pwrite_in;
    assign addr_mapped = (paddr_in == `REG_CONTROL) | (paddr_in == `REG_STATUS) |
        (paddr_in == `REG_CURRENT) | (paddr_in == `REG_RAIL_NOMINAL);
    assign status_read = apb_read & (paddr_in == `REG_STATUS);

    assign status_word = {23'h00_0000,
        path_battery_on_out,
        path_supply_on_out,
        rail_sag_q,
        charge_enable_out,
        under_voltage,
        over_voltage,
        wall_mode_q,
        input_valid,
        event_flag_q};
    assign current_word = {4'h0, pre_ma, 4'h0, fast_ma};

    always @* begin
        control_d = control_q;
        rail_nominal_d = rail_nominal_q;
        if (apb_write && paddr_in == `REG_CONTROL && pstrb_in[0]) begin
            control_d = pwdata_in[`CTL_W-1:0];
        end
        if (apb_write && paddr_in == `REG_RAIL_NOMINAL) begin
            if (pstrb_in[0]) begin
                rail_nominal_d[7:0] = pwdata_in[7:0];
            end
            if (pstrb_in[1]) begin
                rail_nominal_d[`MV_W-1:8] = pwdata_in[`MV_W-1:8];
            end
        end
    end

    always @* begin
        case (paddr_in)
            `REG_CONTROL: rdata_d = {27'h000_0000, control_q};
            `REG_STATUS: rdata_d = status_word;
            `REG_CURRENT: rdata_d = current_word;
            `REG_RAIL_NOMINAL: rdata_d = {18'h0_0000, rail_nominal_q};
            default: rdata_d = 32'h0000_0000;
        endcase
        err_d = ~addr_mapped;
    end

    // ************************************************
    // Pending event flag
    // ************************************************
    always @* begin
        event_flag_d = event_flag_q;
        if (status_read) begin
            event_flag_d = 1'b0;
        end
        // A new event in the clearing cycle survives the read
        if (event_set) begin
            event_flag_d = 1'b1;
        end
    end

    // ************************************************
    // Charge enable and power path
    // ************************************************
    always @* begin
        charge_d = input_valid & ~over_voltage & ~under_voltage;
        path_supply_d = input_valid;
        path_battery_d = ~input_valid | (system_demand_ma_in > limit_ma);
    end

    // ************************************************
    // Sequential state
    // ************************************************
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            control_q <= `CTL_RESET;
            rail_nominal_q <= `RAIL_NOMINAL_RESET;
            event_flag_q <= 1'b0;
            valid_prev_q <= 1'b0;
            wall_mode_q <= 1'b0;
            rail_sag_q <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            charge_enable_out <= 1'b0;
            input_limit_ma_out <= `USB_LOW_LIMIT_MA;
            fast_charge_ma_out <= {`MA_W{1'b0}};
            precondition_ma_out <= {`MA_W{1'b0}};
            dynamic_charge_current_control_out <= 1'b0;
            path_supply_on_out <= 1'b0;
            path_battery_on_out <= 1'b1;
            interrupt_request_n_out <= 1'b1;
        end else begin
            control_q <= control_d;
            rail_nominal_q <= rail_nominal_d;
            event_flag_q <= event_flag_d;
            valid_prev_q <= input_valid;
            wall_mode_q <= wall_input_select_mv_in > `WALL_THRESH_MV;
            rail_sag_q <= rail_sag_d;
            pready_out <= apb_access & ~pready_out;
            if (apb_access && !pready_out) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_d;
                pslverr_out <= err_d;
            end else begin
                pslverr_out <= 1'b0;
            end
            charge_enable_out <= charge_d;
            input_limit_ma_out <= limit_ma;
            fast_charge_ma_out <= fast_ma;
            precondition_ma_out <= pre_ma;
            dynamic_charge_current_control_out <= rail_sag_q;
            path_supply_on_out <= path_supply_d;
            path_battery_on_out <= path_battery_d;
            // Line follows the flag, so it rises only after the status read
            interrupt_request_n_out <= ~event_flag_d;
        end
    end
endmodule // charger_input_supervisor

// >>> core/current_mode_select.v
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"

module current_mode_select (
    input wire clock_in,
    input wire nrst_in,
    input wire wall_mode_in,
    input wire charge_level_select_in,
    input wire rail_sag_in,
    input wire [`MA_W-1:0] resistor_ma_in,
    output reg [`MA_W-1:0] input_limit_ma_out,
    output reg [`MA_W-1:0] fast_ma_out,
    output reg [`MA_W-1:0] pre_ma_out
);
    reg [`MA_W-1:0] limit_d;
    reg [`MA_W-1:0] fast_d;
    reg [`MA_W-1:0] pre_d;

    always @* begin
        case ({wall_mode_in, charge_level_select_in})
            2'b00: begin
                limit_d = `USB_LOW_LIMIT_MA;
                fast_d = `USB_LOW_FAST_MA;
                pre_d = `USB_PRE_MA;
            end
            2'b01: begin
                limit_d = `USB_HIGH_LIMIT_MA;
                fast_d = `USB_HIGH_FAST_MA;
                pre_d = `USB_PRE_MA;
            end
            2'b10: begin
                limit_d = `AC_LIMIT_MA;
                fast_d = resistor_ma_in / `AC_LOW_DIVISOR;
                pre_d = resistor_ma_in / `AC_PRE_DIVISOR;
            end
            default: begin
                limit_d = `AC_LIMIT_MA;
                fast_d = resistor_ma_in;
                pre_d = resistor_ma_in / `AC_PRE_DIVISOR;
            end
        endcase
        // Halving while the rail sags keeps the adapter inside its budget
        if (rail_sag_in) begin
            fast_d = {1'b0, fast_d[`MA_W-1:1]};
            pre_d = {1'b0, pre_d[`MA_W-1:1]};
        end
    end

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            input_limit_ma_out <= `USB_LOW_LIMIT_MA;
            fast_ma_out <= {`MA_W{1'b0}};
            pre_ma_out <= {`MA_W{1'b0}};
        end else begin
            input_limit_ma_out <= limit_d;
            fast_ma_out <= fast_d;
            pre_ma_out <= pre_d;
        end
    end
endmodule // current_mode_select

// >>> core/supply_qualifier.v
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"

module supply_qualifier (
    input wire clock_in,
    input wire nrst_in,
    input wire [`MV_W-1:0] supply_mv_in,
    input wire [1:0] ovp_threshold_select_in,
    output reg over_voltage_out,
    output reg under_voltage_out,
    output reg input_valid_out
);
    reg [`MV_W-1:0] ovp_thresh;
    reg ovp_d;
    reg uv_d;

    always @* begin
        case (ovp_threshold_select_in)
            2'b00: ovp_thresh = `OVP_MV_SEL0;
            2'b01: ovp_thresh = `OVP_MV_SEL1;
            2'b10: ovp_thresh = `OVP_MV_SEL2;
            default: ovp_thresh = `OVP_MV_SEL3;
        endcase
    end

    always @* begin
        ovp_d = over_voltage_out;
        if (supply_mv_in > ovp_thresh) begin
            ovp_d = 1'b1;
        end else if (supply_mv_in < `OVP_RESUME_MV) begin
            // Release ignores the selected threshold on purpose
            ovp_d = 1'b0;
        end
        uv_d = under_voltage_out;
        if (supply_mv_in < `UVLO_MV) begin
            uv_d = 1'b1;
        end else if (supply_mv_in >= `UVLO_MV + `UVLO_HYST_MV) begin
            uv_d = 1'b0;
        end
    end

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // Start flagged as undervoltage until a real reading arrives
            over_voltage_out <= 1'b0;
            under_voltage_out <= 1'b1;
            input_valid_out <= 1'b0;
        end else begin
            over_voltage_out <= ovp_d;
            under_voltage_out <= uv_d;
            input_valid_out <= ~ovp_d & ~uv_d;
        end
    end
endmodule // supply_qualifier

// >>> testbench/charger_input_supervisor_asserts.sv
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"
module charger_input_supervisor_asserts (
    input wire clock_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [`ADDR_W-1:0] paddr_in,
    input wire pready_out,
    input wire [`MV_W-1:0] charger_supply_input_mv_in,
    input wire [`MV_W-1:0] wall_input_select_mv_in,
    input wire charge_level_select_in,
    input wire [`MA_W-1:0] charge_current_resistance_ma_in,
    input wire [`MV_W-1:0] system_rail_mv_in,
    input wire charge_enable_out,
    input wire [`MA_W-1:0] input_limit_ma_out,
    input wire [`MA_W-1:0] fast_charge_ma_out,
    input wire dynamic_charge_current_control_out,
    input wire path_battery_on_out,
    input wire interrupt_request_n_out
);
default clocking cb @(posedge clock_in); endclocking
default disable iff (!nrst_in);
// ****************************************
// Expected settings
// ****************************************
wire [`MV_W-1:0] sup = charger_supply_input_mv_in;
wire [`MA_W-1:0] res = charge_current_resistance_ma_in;
wire lvl = charge_level_select_in;
wire wall = wall_input_select_mv_in > `WALL_THRESH_MV;
wire status_rd = psel_in && penable_in && pready_out && !pwrite_in && paddr_in == `REG_STATUS;
wire [`MA_W-1:0] lim_exp = wall ? `AC_LIMIT_MA : (lvl ? `USB_HIGH_LIMIT_MA : `USB_LOW_LIMIT_MA);
wire [`MA_W-1:0] fast_exp = wall ? (lvl ? res : res / `AC_LOW_DIVISOR)
    : (lvl ? `USB_HIGH_FAST_MA : `USB_LOW_FAST_MA);
// Rail check assumes the nominal rail register keeps its reset value
sequence modes_steady;
    ($stable(wall_input_select_mv_in) && $stable(lvl) && $stable(res)
        && $stable(system_rail_mv_in))[*5];
endsequence
sequence over_then_high;
    (sup > `OVP_MV_SEL3) ##1 (sup >= `OVP_RESUME_MV)[*3];
endsequence
sequence under_then_low;
    (sup < `UVLO_MV) ##1 (sup < `UVLO_MV + `UVLO_HYST_MV)[*3];
endsequence
// ****************************************
// Properties
// ****************************************
a_ovp_blocks: assert property (sup > `OVP_MV_SEL3 |-> ##2 !charge_enable_out)
    else $error("charge stayed on above the top over-voltage limit");
a_ovp_resume_gate: assert property (over_then_high |-> !charge_enable_out)
    else $error("charge resumed before supply fell below resume level");
a_uv_blocks: assert property (sup < `UVLO_MV |-> ##2 !charge_enable_out)
    else $error("charge stayed on under the under-voltage limit");
a_uv_hysteresis: assert property (under_then_low |-> !charge_enable_out)
    else $error("charge resumed inside the under-voltage hysteresis");
a_input_limit: assert property (modes_steady |-> input_limit_ma_out == lim_exp)
    else $error("input current limit does not match mode inputs");
a_fast_current: assert property (modes_steady |->
    dynamic_charge_current_control_out || fast_charge_ma_out == fast_exp)
    else $error("fast charge current does not match mode inputs");
a_rail_sag: assert property (modes_steady |-> dynamic_charge_current_control_out
    == (system_rail_mv_in < `RAIL_NOMINAL_RESET - `RAIL_SAG_MV))
    else $error("rail sag control disagrees with rail level");
a_battery_path: assert property ((sup < `UVLO_MV)[*3] |-> path_battery_on_out)
    else $error("battery path off without valid supply");
a_irq_holds: assert property (!interrupt_request_n_out && !status_rd
    |=> !interrupt_request_n_out)
    else $error("interrupt line released without a status read");
endmodule // charger_input_supervisor_asserts

// >>> testbench/supply_side_model.sv
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"
module supply_side_model #(
    parameter [`MV_W-1:0] SLEW_MV = 14'h07d0
) (
    input wire clock_in,
    input wire nrst_in,
    input wire [`MV_W-1:0] supply_goal_in,
    input wire [`MV_W-1:0] wall_goal_in,
    input wire [`MV_W-1:0] rail_goal_in,
    input wire [`MA_W-1:0] demand_goal_in,
    output reg [`MV_W-1:0] supply_mv_out,
    output reg [`MV_W-1:0] wall_mv_out,
    output reg [`MV_W-1:0] rail_mv_out,
    output reg [`MA_W-1:0] demand_ma_out
);
// Supply ramps like a real adapter, so a plug crosses every threshold on its way
always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        supply_mv_out <= supply_goal_in;
    end else if (supply_mv_out + SLEW_MV < supply_goal_in) begin
        supply_mv_out <= supply_mv_out + SLEW_MV;
    end else if (supply_goal_in + SLEW_MV < supply_mv_out) begin
        supply_mv_out <= supply_mv_out - SLEW_MV;
    end else begin
        supply_mv_out <= supply_goal_in;
    end
end
always @(posedge clock_in) begin
    wall_mv_out <= wall_goal_in;
    rail_mv_out <= rail_goal_in;
    demand_ma_out <= demand_goal_in;
end
endmodule // supply_side_model

// >>> testbench/test_charger_input_supervisor.sv
`timescale 1ns/100ps
`include "charger_input_supervisor_consts.vh"
module test_charger_input_supervisor;
reg clock_in = 1'b0;
reg nrst_in = 1'b0;
reg psel_in = 1'b0;
reg penable_in = 1'b0;
reg pwrite_in = 1'b0;
reg [`ADDR_W-1:0] paddr_in = 12'h000;
reg [31:0] pwdata_in = 32'h0000_0000;
reg [3:0] pstrb_in = 4'hf;
reg level_sel = 1'b0;
reg [`MA_W-1:0] res_ma = 12'h3e8;
reg [`MV_W-1:0] supply_goal = 14'h0000;
reg [`MV_W-1:0] wall_goal = 14'h0000;
reg [`MV_W-1:0] rail_goal = `RAIL_NOMINAL_RESET;
reg [`MA_W-1:0] demand_goal = 12'h000;
wire [`MV_W-1:0] supply_mv;
wire [`MV_W-1:0] wall_mv;
wire [`MV_W-1:0] rail_mv;
wire [`MA_W-1:0] demand_ma;
wire [31:0] prdata_out;
wire pready_out;
wire pslverr_out;
wire charge_enable_out;
wire [`MA_W-1:0] input_limit_ma_out;
wire [`MA_W-1:0] fast_charge_ma_out;
wire [`MA_W-1:0] precondition_ma_out;
wire dynamic_charge_current_control_out;
wire path_supply_on_out;
wire path_battery_on_out;
wire interrupt_request_n_out;
integer miscompares = 0;
integer samples_checked = 0;
integer i;
reg [31:0] q;
reg err;
reg [`MA_W-1:0] fast;
reg [`MA_W-1:0] pre;
reg [`MV_W-1:0] thr;
always #4 clock_in = ~clock_in;
supply_side_model supply_side_model_inst (.clock_in(clock_in), .nrst_in(nrst_in),
    .supply_goal_in(supply_goal), .wall_goal_in(wall_goal), .rail_goal_in(rail_goal),
    .demand_goal_in(demand_goal), .supply_mv_out(supply_mv), .wall_mv_out(wall_mv),
    .rail_mv_out(rail_mv), .demand_ma_out(demand_ma));
charger_input_supervisor charger_input_supervisor_inst (.clock_in(clock_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .charger_supply_input_mv_in(supply_mv),
    .wall_input_select_mv_in(wall_mv), .charge_level_select_in(level_sel),
    .charge_current_resistance_ma_in(res_ma), .system_rail_mv_in(rail_mv),
    .system_demand_ma_in(demand_ma), .charge_enable_out(charge_enable_out),
    .input_limit_ma_out(input_limit_ma_out), .fast_charge_ma_out(fast_charge_ma_out),
    .precondition_ma_out(precondition_ma_out),
    .dynamic_charge_current_control_out(dynamic_charge_current_control_out),
    .path_supply_on_out(path_supply_on_out), .path_battery_on_out(path_battery_on_out),
    .interrupt_request_n_out(interrupt_request_n_out));
// ****************************************
// Access tasks
// ****************************************
task check(input string what, input [31:0] exp, input [31:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    end
endtask
task apb(input w, input [`ADDR_W-1:0] a, input [31:0] d);
    integer n;
    begin
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        @(posedge clock_in);
        while (pready_out !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            n = n + 1;
        end
        check("bus answer", 1, pready_out);
        q = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    end
endtask
task rd_check(input [`ADDR_W-1:0] a, input [31:0] exp, input string what);
    begin
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, q);
    end
endtask
// Analog levels need several edges to pass the qualifier and output flops
task settle;
    repeat (12) @(posedge clock_in);
endtask
task set_supply(input [`MV_W-1:0] v);
    begin
        supply_goal <= v;
        settle;
    end
endtask
task stop_test;
    begin
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask
initial begin
    repeat (20000) @(posedge clock_in);
    $display("MISMATCH watchdog expected finish seen timeout");
    miscompares = miscompares + 1;
    stop_test;
end
// ****************************************
// Tests
// ****************************************
initial begin
    repeat (20) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd_check(`REG_CONTROL, 32'h0000_0000, "control reset");
    rd_check(`REG_RAIL_NOMINAL, {18'h0_0000, `RAIL_NOMINAL_RESET}, "nominal reset");
    rd_check(`REG_STATUS, 32'h0000_0110, "status reset");
    rd_check(12'h010, 32'h0000_0000, "unmapped data");
    check("unmapped error", 1, err);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
        wall_goal <= i[1] ? `WALL_THRESH_MV + 14'h0001 : `WALL_THRESH_MV;
        level_sel <= i[0];
        set_supply(14'h1388);
        fast = i[1] ? (i[0] ? res_ma : res_ma / `AC_LOW_DIVISOR)
            : (i[0] ? `USB_HIGH_FAST_MA : `USB_LOW_FAST_MA);
        pre = i[1] ? res_ma / `AC_PRE_DIVISOR : `USB_PRE_MA;
        check("limit", i[1] ? `AC_LIMIT_MA : (i[0] ? `USB_HIGH_LIMIT_MA : `USB_LOW_LIMIT_MA),
            input_limit_ma_out);
        check("fast", fast, fast_charge_ma_out);
        check("pre", pre, precondition_ma_out);
        rd_check(`REG_CURRENT, {4'h0, pre, 4'h0, fast}, "current reg");
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check("wall status", i[1], q[`ST_WALL_BIT]);
    end
    $display("test modes done");
    wall_goal <= 14'h0000;
    level_sel <= 1'b0;
    apb(1'b1, `REG_CONTROL, 32'h0000_001c);
    set_supply(14'h0000);
    set_supply(14'h1388);
    check("irq", 0, interrupt_request_n_out);
    rd_check(`REG_STATUS, 32'h0000_00a3, "merged event");
    settle;
    check("irq", 1, interrupt_request_n_out);
    rd_check(`REG_STATUS, 32'h0000_00a2, "flag cleared");
    apb(1'b1, `REG_CONTROL, 32'h0000_0014);
    set_supply(14'h0000);
    check("irq", 0, interrupt_request_n_out);
    rd_check(`REG_STATUS, 32'h0000_0111, "disconnect");
    set_supply(14'h1388);
    check("irq", 1, interrupt_request_n_out);
    apb(1'b1, `REG_CONTROL, 32'h0000_0018);
    set_supply(14'h0000);
    check("irq", 1, interrupt_request_n_out);
    apb(1'b1, `REG_CONTROL, 32'h0000_000c);
    set_supply(14'h1388);
    check("irq", 0, interrupt_request_n_out);
    rd_check(`REG_STATUS, 32'h0000_00a3, "connect");
    $display("test events done");
    for (i = 0; i < 4; i = i + 1) begin
        thr = i == 0 ? `OVP_MV_SEL0 : i == 1 ? `OVP_MV_SEL1 : i == 2 ? `OVP_MV_SEL2 : `OVP_MV_SEL3;
        apb(1'b1, `REG_CONTROL, i);
        set_supply(thr);
        check("charge at limit", 1, charge_enable_out);
        set_supply(thr + 14'h0001);
        check("charge over limit", 0, charge_enable_out);
        set_supply(`OVP_RESUME_MV);
        check("charge at resume", 0, charge_enable_out);
        set_supply(`OVP_RESUME_MV - 14'h0001);
        check("charge resumed", 1, charge_enable_out);
    end
    $display("test over-voltage done");
    set_supply(`UVLO_MV - 14'h0001);
    check("charge under", 0, charge_enable_out);
    check("battery path", 1, path_battery_on_out);
    check("supply path", 0, path_supply_on_out);
    set_supply(`UVLO_MV + `UVLO_HYST_MV - 14'h0001);
    check("charge hysteresis", 0, charge_enable_out);
    set_supply(`UVLO_MV + `UVLO_HYST_MV);
    check("charge restart", 1, charge_enable_out);
    rail_goal <= `RAIL_NOMINAL_RESET - `RAIL_SAG_MV - 14'h0001;
    settle;
    check("sag control", 1, dynamic_charge_current_control_out);
    check("sag fast", `USB_LOW_FAST_MA >> 1, fast_charge_ma_out);
    rail_goal <= `RAIL_NOMINAL_RESET - `RAIL_SAG_MV;
    demand_goal <= `USB_LOW_LIMIT_MA + 12'h001;
    settle;
    check("no sag", 0, dynamic_charge_current_control_out);
    check("both paths", 2'b11, {path_supply_on_out, path_battery_on_out});
    demand_goal <= `USB_LOW_LIMIT_MA;
    settle;
    check("supply only", 2'b10, {path_supply_on_out, path_battery_on_out});
    $display("test supply and paths done");
    stop_test;
end
endmodule // test_charger_input_supervisor
// Checker ports carry the design's own port names, so a wildcard connects them
bind charger_input_supervisor charger_input_supervisor_asserts charger_input_supervisor_asserts_inst (
    .*);
